// File: hdl/ums_modem_line_status.sv
//==========================================================================
// Purpose: Modem control, line status and modem status for one channel
// Assumes: All inputs synchronous to pclk; zero-wait APB slave
// Notes:   Receive characters buffered here; transmit buffer is outside
//==========================================================================
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
module ums_modem_line_status #(
   parameter int DEPTH = ums_pkg::UMS_RX_DEPTH // Receive buffer depth
) (
   input  wire logic                        pclk,          // Clock
   input  wire logic                        presetn,       // Async reset
   input  wire logic                        psel,          // APB select
   input  wire logic                        penable,       // APB enable
   input  wire logic                        pwrite,        // APB write
   input  wire logic [7:0]                  paddr,         // APB address
   input  wire logic [31:0]                 pwdata,        // APB wdata
   output logic [31:0]                      prdata,        // APB rdata
   output logic                             pready,        // APB ready
   output logic                             pslverr,       // APB error
   input  wire ums_pkg::ums_modem_pins_type modem_pins,    // Modem inputs
   output logic                             rts_n,         // RTS pin
   output logic                             dtr_n,         // DTR pin
   input  wire logic                        rx_line,       // RX pin level
   input  wire logic                        rx_valid,      // Char done
   input  wire ums_pkg::ums_rx_char_type    rx_char,       // Char + tags
   input  wire logic                        tx_fifo_valid, // Buffer data
   input  wire logic [7:0]                  tx_fifo_data,  // Buffer head
   output logic                             tx_fifo_pop,   // Take head
   output logic                             tx_write,      // Holding wr
   output logic [7:0]                       tx_write_data, // Holding data
   input  wire logic                        flow_valid,    // Xon/Xoff due
   input  wire logic [7:0]                  flow_data,     // Flow char
   output logic                             flow_pop,      // Take flow
   input  wire logic                        xoff_halted,   // Soft halt
   output logic                             xon_resume,    // Any-char Xon
   input  wire logic                        tsr_idle,      // Shifter free
   output logic                             tsr_load,      // Load pulse
   output logic [7:0]                       tsr_data,      // Load byte
   output logic                             ls_irq,        // Line irq
   output logic                             ms_irq         // Modem irq
);
   import ums_pkg::*;

   localparam int CW = $clog2(DEPTH + 1);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   // Pointer advance with wrap
   function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
      ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
   endfunction : ptr_inc

   // Error tag of an entry
   function automatic logic has_err(input ums_rx_char_type c);
      has_err = c.pe | c.fe | c.brk;
   endfunction : has_err

   //=======================================================================
   // APB decode
   //=======================================================================
   logic       acc;
   logic       setup;
   logic       wr;
   logic       rd;
   logic       mapped;
   always_comb begin
      setup  = psel & ~penable;
      acc    = psel & penable;
      wr     = acc & pwrite;
      rd     = acc & ~pwrite;
      mapped = (paddr == UMS_OFS_MODEM_CONTROL) |
               (paddr == UMS_OFS_LINE_STATUS) |
               (paddr == UMS_OFS_MODEM_STATUS) |
               (paddr == UMS_OFS_FEATURE) |
               (paddr == UMS_OFS_HOLDING);
   end
   assign pready  = 1'b1;
   assign pslverr = acc & ~mapped;

   //=======================================================================
   // Control registers and send-immediate
   //=======================================================================
   logic [7:0] mc_ff,   nxt_mc;
   logic [5:0] ft_ff,   nxt_ft;
   logic       arm_ff,  nxt_arm;
   logic       imm_ff,  nxt_imm;
   logic [7:0] immd_ff, nxt_immd;
   logic       txw_ff,  nxt_txw;
   logic [7:0] txwd_ff, nxt_txwd;
   logic       loop;
   logic       tx_dis;
   logic       load_go;
   ums_src_type src;

   assign loop   = mc_ff[UMS_MC_LOOP];
   assign tx_dis = ft_ff[UMS_FT_TX_DIS];

   // Register writes and the armed holding write
   always_comb begin
      nxt_mc   = mc_ff;
      nxt_ft   = ft_ff;
      nxt_arm  = arm_ff;
      nxt_imm  = imm_ff;
      nxt_immd = immd_ff;
      nxt_txw  = 1'b0;
      nxt_txwd = txwd_ff;
      if (acc && arm_ff) begin
         nxt_arm = 1'b0;
         if (wr && paddr == UMS_OFS_HOLDING) begin
            nxt_imm  = 1'b1;
            nxt_immd = pwdata[7:0];
         end else begin
            nxt_mc[UMS_MC_SEND_IMM] = 1'b0;
         end
      end else if (wr && paddr == UMS_OFS_HOLDING) begin
         nxt_txw  = 1'b1;
         nxt_txwd = pwdata[7:0];
      end
      if (wr && paddr == UMS_OFS_MODEM_CONTROL) begin
         nxt_mc = pwdata[7:0];
         // Arm only outside loopback, transmitter enabled
         nxt_arm = pwdata[UMS_MC_SEND_IMM] & ~pwdata[UMS_MC_LOOP] &
                   ~tx_dis;
      end
      if (wr && paddr == UMS_OFS_FEATURE)
         nxt_ft = pwdata[5:0];
      // Self clear once the byte enters the shifter
      if (load_go && src == UMS_SRC_IMM) begin
         nxt_imm = 1'b0;
         nxt_mc[UMS_MC_SEND_IMM] = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mc_ff   <= UMS_RST_MODEM_CONTROL;
         ft_ff   <= UMS_RST_FEATURE;
         arm_ff  <= 1'b0;
         imm_ff  <= 1'b0;
         immd_ff <= 8'h00;
         txw_ff  <= 1'b0;
         txwd_ff <= 8'h00;
      end else begin
         mc_ff   <= nxt_mc;
         ft_ff   <= nxt_ft;
         arm_ff  <= nxt_arm;
         imm_ff  <= nxt_imm;
         immd_ff <= nxt_immd;
         txw_ff  <= nxt_txw;
         txwd_ff <= nxt_txwd;
      end
   end
   assign tx_write      = txw_ff;
   assign tx_write_data = txwd_ff;

   //=======================================================================
   // Transmit source arbitration and flow control
   //=======================================================================
   logic       hw_halt;
   logic       ld_ff,  nxt_ld;
   logic [7:0] ldd_ff, nxt_ldd;
   logic       rts_ff, nxt_rts;
   logic       dtr_ff, nxt_dtr;

   // Selected flow input, stop when high
   always_comb begin
      hw_halt = 1'b0;
      if (ft_ff[UMS_FT_AUTOFLOW])
         hw_halt = mc_ff[UMS_MC_FLOW_SEL] ? modem_pins.dsr_n
                                          : modem_pins.cts_n;
   end

   // Flow chars first, then immediate byte, then buffer
   always_comb begin
      src = UMS_SRC_NONE;
      if (flow_valid)
         src = UMS_SRC_FLOW;
      else if (imm_ff && !hw_halt)
         src = UMS_SRC_IMM;
      else if (tx_fifo_valid && !hw_halt && !xoff_halted)
         src = UMS_SRC_FIFO;
      // Loads only between characters, never while disabled
      load_go     = tsr_idle & ~ld_ff & ~tx_dis &
                    (src != UMS_SRC_NONE);
      flow_pop    = load_go & (src == UMS_SRC_FLOW);
      tx_fifo_pop = load_go & (src == UMS_SRC_FIFO);
      nxt_ld      = load_go;
      nxt_ldd     = ldd_ff;
      unique case (src)
         UMS_SRC_FLOW: nxt_ldd = flow_data;
         UMS_SRC_IMM:  nxt_ldd = immd_ff;
         UMS_SRC_FIFO: nxt_ldd = tx_fifo_data;
         UMS_SRC_NONE: nxt_ldd = ldd_ff;
      endcase
      if (!load_go)
         nxt_ldd = ldd_ff;
      nxt_rts = ~mc_ff[UMS_MC_RTS];
      nxt_dtr = ~mc_ff[UMS_MC_DTR];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ld_ff  <= 1'b0;
         ldd_ff <= 8'h00;
         rts_ff <= 1'b1;
         dtr_ff <= 1'b1;
      end else begin
         ld_ff  <= nxt_ld;
         ldd_ff <= nxt_ldd;
         rts_ff <= nxt_rts;
         dtr_ff <= nxt_dtr;
      end
   end
   assign tsr_load = ld_ff;
   assign tsr_data = ldd_ff;
   assign rts_n    = rts_ff;
   assign dtr_n    = dtr_ff;

   //=======================================================================
   // Receive buffer and line status
   //=======================================================================
   ums_rx_char_type mem [DEPTH];
   logic [AW-1:0] wp_ff,  nxt_wp;
   logic [AW-1:0] rp_ff,  nxt_rp;
   logic [CW-1:0] cnt_ff, nxt_cnt;
   logic [CW-1:0] ecnt_ff, nxt_ecnt;
   logic          oe_ff,  nxt_oe;
   logic          bh_ff,  nxt_bh;
   logic          xr_ff,  nxt_xr;
   logic          full;
   logic          push;
   logic          pop;
   ums_rx_char_type top;
   logic [7:0]    ls_val;

   assign top = mem[rp_ff];

   // Push, pop, overrun and break hold
   always_comb begin
      full = ft_ff[UMS_FT_FIFO_EN] ? (cnt_ff == CW'(DEPTH))
                                   : (cnt_ff != '0);
      pop  = rd && paddr == UMS_OFS_HOLDING && cnt_ff != '0;
      // With buffer enabled, repeat breaks dropped while the line stays low
      push = rx_valid & ~(rx_char.brk & bh_ff) & (~full | pop);
      nxt_wp   = push ? ptr_inc(wp_ff) : wp_ff;
      nxt_rp   = pop  ? ptr_inc(rp_ff) : rp_ff;
      nxt_cnt  = cnt_ff + CW'(push) - CW'(pop);
      nxt_ecnt = ecnt_ff + CW'(push & has_err(rx_char))
                 - CW'(pop & has_err(top));
      nxt_oe   = oe_ff;
      if (rd && paddr == UMS_OFS_LINE_STATUS)
         nxt_oe = 1'b0;
      if (rx_valid && full && !pop)
         nxt_oe = 1'b1;
      nxt_bh = bh_ff;
      if (rx_line)
         nxt_bh = 1'b0;
      if (push && rx_char.brk && ft_ff[UMS_FT_FIFO_EN])
         nxt_bh = 1'b1;
      nxt_xr = rx_valid & mc_ff[UMS_MC_XON_ANY] &
               ft_ff[UMS_FT_UNLOCK];
   end

   always_ff @(posedge pclk) begin
      if (push)
         mem[wp_ff] <= rx_char;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wp_ff   <= '0;
         rp_ff   <= '0;
         cnt_ff  <= '0;
         ecnt_ff <= '0;
         oe_ff   <= 1'b0;
         bh_ff   <= 1'b0;
         xr_ff   <= 1'b0;
      end else begin
         wp_ff   <= nxt_wp;
         rp_ff   <= nxt_rp;
         cnt_ff  <= nxt_cnt;
         ecnt_ff <= nxt_ecnt;
         oe_ff   <= nxt_oe;
         bh_ff   <= nxt_bh;
         xr_ff   <= nxt_xr;
      end
   end
   assign xon_resume = xr_ff;

   // Line status word
   always_comb begin
      ls_val = 8'h00;
      ls_val[UMS_LS_DR]   = cnt_ff != '0;
      ls_val[UMS_LS_OE]   = oe_ff;
      ls_val[UMS_LS_PE]   = (cnt_ff != '0) & top.pe;
      ls_val[UMS_LS_FE]   = (cnt_ff != '0) & top.fe;
      ls_val[UMS_LS_BI]   = ((cnt_ff != '0) & top.brk) | bh_ff;
      ls_val[UMS_LS_THRE] = ~tx_fifo_valid & ~imm_ff;
      ls_val[UMS_LS_TEMT] = ~tx_fifo_valid & ~imm_ff &
                            tsr_idle & ~ld_ff;
      ls_val[UMS_LS_ERR]  = ecnt_ff != '0;
   end

   //=======================================================================
   // Modem status and deltas
   //=======================================================================
   logic [3:0] ms_now;
   logic [3:0] prev_ff, nxt_prev;
   logic [3:0] dl_ff,   nxt_dl;
   logic       vld_ff;
   logic [7:0] ms_val;

   // Status bits order: cd, ri, dsr, cts
   always_comb begin
      if (loop)
         ms_now = {mc_ff[UMS_MC_SEND_IMM], mc_ff[UMS_MC_FLOW_SEL],
                   mc_ff[UMS_MC_DTR], mc_ff[UMS_MC_RTS]};
      else
         ms_now = ~{modem_pins.cd_n, modem_pins.ri_n,
                    modem_pins.dsr_n, modem_pins.cts_n};
      nxt_prev = ms_now;
      nxt_dl   = dl_ff;
      if (rd && paddr == UMS_OFS_MODEM_STATUS)
         nxt_dl = 4'h0;
      if (vld_ff) begin
         nxt_dl[3] = nxt_dl[3] | (ms_now[3] ^ prev_ff[3]);
         nxt_dl[2] = nxt_dl[2] | (prev_ff[2] & ~ms_now[2]);
         nxt_dl[1] = nxt_dl[1] | (ms_now[1] ^ prev_ff[1]);
         nxt_dl[0] = nxt_dl[0] | (ms_now[0] ^ prev_ff[0]);
      end
      ms_val = {ms_now, dl_ff};
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_ff <= 4'h0;
         dl_ff   <= 4'h0;
         vld_ff  <= 1'b0;
      end else begin
         prev_ff <= nxt_prev;
         dl_ff   <= nxt_dl;
         vld_ff  <= 1'b1;
      end
   end

   //=======================================================================
   // Read data and interrupt requests
   //=======================================================================
   logic [31:0] rdat_ff, nxt_rdat;
   logic        lsi_ff,  nxt_lsi;
   logic        msi_ff,  nxt_msi;
   always_comb begin
      nxt_rdat = rdat_ff;
      if (setup) begin
         unique case (paddr)
            UMS_OFS_MODEM_CONTROL: nxt_rdat = {24'h000000, mc_ff};
            UMS_OFS_LINE_STATUS:   nxt_rdat = {24'h000000, ls_val};
            UMS_OFS_MODEM_STATUS:  nxt_rdat = {24'h000000, ms_val};
            UMS_OFS_FEATURE:       nxt_rdat = {26'h0000000, ft_ff};
            UMS_OFS_HOLDING:       nxt_rdat = {24'h000000, top.data};
            default:               nxt_rdat = 32'h00000000;
         endcase
      end
      nxt_lsi = ft_ff[UMS_FT_LS_IE] &
                ((nxt_ecnt != '0) | nxt_oe);
      nxt_msi = ft_ff[UMS_FT_MS_IE] & (nxt_dl != 4'h0);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdat_ff <= 32'h00000000;
         lsi_ff  <= 1'b0;
         msi_ff  <= 1'b0;
      end else begin
         rdat_ff <= nxt_rdat;
         lsi_ff  <= nxt_lsi;
         msi_ff  <= nxt_msi;
      end
   end
   assign prdata = rdat_ff;
   assign ls_irq = lsi_ff;
   assign ms_irq = msi_ff;

   //=======================================================================
   // Assertions
   //=======================================================================
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_mc_write;
      wr && paddr == UMS_OFS_MODEM_CONTROL;
   endsequence
   sequence s_imm_load;
      tsr_load && tsr_data == $past(immd_ff);
   endsequence

   property p_rts_pin;
      s_mc_write ##1 1'b1 |=> rts_n == ~$past(pwdata[UMS_MC_RTS], 2);
   endproperty
   a_rts_pin: assert property (p_rts_pin)
      else $error("rts pin does not follow control bit");

   property p_dtr_pin;
      s_mc_write ##1 1'b1 |=> dtr_n == ~$past(pwdata[UMS_MC_DTR], 2);
   endproperty
   a_dtr_pin: assert property (p_dtr_pin)
      else $error("dtr pin does not follow control bit");

   property p_loop_map;
      loop |-> ms_val[7:4] == {mc_ff[3], mc_ff[2], mc_ff[0], mc_ff[1]};
   endproperty
   a_loop_map: assert property (p_loop_map)
      else $error("loopback status mapping wrong");

   property p_ring_edge;
      !loop && !nxt_dl[2] && modem_pins.ri_n && !rd
         ##1 $fell(modem_pins.ri_n) |=> !dl_ff[2];
   endproperty
   a_ring_edge: assert property (p_ring_edge)
      else $error("ring delta set on falling ring pin");

   property p_delta_clear;
      rd && paddr == UMS_OFS_MODEM_STATUS && ms_now == prev_ff
         |=> dl_ff == 4'h0;
   endproperty
   a_delta_clear: assert property (p_delta_clear)
      else $error("delta flags not cleared by read");

   property p_overrun;
      rx_valid && full && !pop |=> oe_ff && cnt_ff == $past(cnt_ff);
   endproperty
   a_overrun: assert property (p_overrun)
      else $error("overrun not flagged or buffer changed");

   property p_err_sum;
      ls_val[UMS_LS_ERR] == (ecnt_ff != '0) && ecnt_ff <= cnt_ff;
   endproperty
   a_err_sum: assert property (p_err_sum)
      else $error("error summary inconsistent");

   property p_imm_first;
      imm_ff && !flow_valid && !hw_halt && tsr_idle && !ld_ff &&
         !tx_dis |=> s_imm_load ##1 !mc_ff[UMS_MC_SEND_IMM];
   endproperty
   a_imm_first: assert property (p_imm_first)
      else $error("immediate byte not sent next or bit kept");

   property p_halt;
      hw_halt |-> !tx_fifo_pop && !(load_go && src == UMS_SRC_IMM);
   endproperty
   a_halt: assert property (p_halt)
      else $error("load while flow input halts");

   property p_dready;
      push |=> ls_val[UMS_LS_DR];
   endproperty
   a_dready: assert property (p_dready)
      else $error("data ready wrong");
endmodule : ums_modem_line_status

// File: hdl/ums_pkg.sv
//==========================================================================
// Purpose: Constants and types for the modem and line status block
// Assumes: APB register access, one aligned 32-bit word per register
// Notes:   Summary of rules follows
//==========================================================================
// Summary of operation
// - Xon-any with unlock: any received character resumes
// - Loopback: carrier and ring follow control bits
// - Loopback: DSR follows DTR, CTS follows RTS
// - Immediate byte next, then request bit self-clears
// - Flow characters first; needs transmitter enabled
// - Select bit picks RTS/CTS or DTR/DSR flow
// - RTS bit drives active-low RTS pin
// - DTR bit drives active-low DTR pin
// - Errored receive entry raises line-status interrupt
// - Error summary set while errored entries remain
// - Transmitter empty when buffer and shifter empty
// - Transmit buffer empty flag tracks holding data
// - With buffer enabled, one break stored; indication holds until idle
// - Framing error tied to readable character
// - Parity error tied to readable character
// - Full buffer: set overrun, drop new character
// - Data ready while any character is held
// - Outside loopback, status shows inverted pins
// - Flow input high stops after current character
// - Carrier, DSR, CTS changes set delta flags
// - Ring delta only on ring pin rising
package ums_pkg;
   // Register byte offsets
   localparam logic [7:0] UMS_OFS_MODEM_CONTROL = 8'h00;
   localparam logic [7:0] UMS_OFS_LINE_STATUS   = 8'h04;
   localparam logic [7:0] UMS_OFS_MODEM_STATUS  = 8'h08;
   localparam logic [7:0] UMS_OFS_FEATURE       = 8'h0C;
   localparam logic [7:0] UMS_OFS_HOLDING       = 8'h10;
   // Modem control fields
   localparam int UMS_MC_DTR      = 0;
   localparam int UMS_MC_RTS      = 1;
   localparam int UMS_MC_FLOW_SEL = 2;
   localparam int UMS_MC_SEND_IMM = 3;
   localparam int UMS_MC_LOOP     = 4;
   localparam int UMS_MC_XON_ANY  = 5;
   // Feature register fields
   localparam int UMS_FT_UNLOCK   = 0;
   localparam int UMS_FT_AUTOFLOW = 1;
   localparam int UMS_FT_FIFO_EN  = 2;
   localparam int UMS_FT_LS_IE    = 3;
   localparam int UMS_FT_MS_IE    = 4;
   localparam int UMS_FT_TX_DIS   = 5;
   // Line status fields
   localparam int UMS_LS_DR   = 0;
   localparam int UMS_LS_OE   = 1;
   localparam int UMS_LS_PE   = 2;
   localparam int UMS_LS_FE   = 3;
   localparam int UMS_LS_BI   = 4;
   localparam int UMS_LS_THRE = 5;
   localparam int UMS_LS_TEMT = 6;
   localparam int UMS_LS_ERR  = 7;
   // Reset values
   localparam logic [7:0] UMS_RST_MODEM_CONTROL = 8'h00;
   localparam logic [5:0] UMS_RST_FEATURE       = 6'h00;
   // Receive depth default
   localparam int UMS_RX_DEPTH = 64;

   // One received character with its error tags
   typedef struct packed {
      logic       brk;
      logic       fe;
      logic       pe;
      logic [7:0] data;
   } ums_rx_char_type;

   // Modem input pins, all active low
   typedef struct packed {
      logic cd_n;
      logic ri_n;
      logic dsr_n;
      logic cts_n;
   } ums_modem_pins_type;

   // Transmit source selection
   typedef enum logic [1:0] {
      UMS_SRC_NONE,
      UMS_SRC_FLOW,
      UMS_SRC_IMM,
      UMS_SRC_FIFO
   } ums_src_type;
endpackage : ums_pkg

// File: verification/test_ums_modem_line_status.sv
//========
// Purpose: Self-checking bench for the modem and line status block
// Assumes: Zero-wait APB slave, receive depth of four
// Notes:   Modem rows in a table, then hand-written cases
//========
`timescale 1ns/100ps
module test_ums_modem_line_status;
   import ums_pkg::*;
   logic pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, rx_valid = 1'b0, rxl = 1'b1, pready, pslverr, err;
   logic [7:0] paddr = 8'h00, tx_fifo_data = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic rts_n, dtr_n, tx_fifo_pop, tx_write, flow_pop, xon_resume;
   logic tsr_idle, tsr_load, ls_irq, ms_irq;
   logic [7:0] tx_write_data, tsr_data;
   logic [1:0] tx_left;
   ums_rx_char_type rx_char = '0;
   ums_modem_pins_type pins_cmd = '1, modem_pins;
   logic [7:0] ldq[$];
   int fails = 0, checks = 0, xon_n = 0, n;
   logic [7:0] mc_t[4] = '{8'h03, 8'h00, 8'h17, 8'h19};
   logic [3:0] pn_t[4] = '{4'hA, 4'h5, 4'h0, 4'h0};
   logic [3:0] ex_t[4] = '{4'h5, 4'hA, 4'h7, 4'hA};
   ums_modem_line_status #(.DEPTH(4)) u_ums_modem_line_status (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .modem_pins(modem_pins),
      .rts_n(rts_n), .dtr_n(dtr_n), .rx_line(rxl), .rx_valid(rx_valid),
      .rx_char(rx_char), .tx_fifo_valid(tx_left != 2'h0),
      .tx_fifo_data(tx_fifo_data), .tx_fifo_pop(tx_fifo_pop),
      .tx_write(tx_write), .tx_write_data(tx_write_data),
      .flow_valid(1'b0), .flow_data(8'h00), .flow_pop(flow_pop),
      .xoff_halted(1'b0), .xon_resume(xon_resume), .tsr_idle(tsr_idle),
      .tsr_load(tsr_load), .tsr_data(tsr_data), .ls_irq(ls_irq),
      .ms_irq(ms_irq));
   ums_modem_model u_ums_modem_model (.pclk(pclk), .presetn(presetn),
      .pins_cmd(pins_cmd), .tsr_load(tsr_load), .modem_pins(modem_pins),
      .tsr_idle(tsr_idle));
   // Clock
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   // Transmit buffer stand-in, load and resume monitors
   always @(posedge pclk) begin
      if (tsr_load === 1'b1) ldq.push_back(tsr_data);
      if (xon_resume === 1'b1) xon_n++;
      if (tx_write === 1'b1) tx_fifo_data <= tx_write_data;
      if (!presetn) tx_left <= 2'h0;
      else tx_left <= tx_left + {1'b0, tx_write} - {1'b0, tx_fifo_pop};
   end
   task results;
      if (fails == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : results
   task chk(input logic [7:0] g, input logic [7:0] e);
      checks++;
      if (g !== e) begin
         fails++;
         $display("mismatch %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task guard;
      if (n >= 100) begin
         fails++;
         results();
      end
   endtask : guard
   // One APB transfer, then an idle cycle
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 100);
      guard();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task rx(input logic [10:0] c);
      rx_char <= c;
      rx_valid <= 1'b1;
      @(posedge pclk);
      rx_valid <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask : rx
   // Main sequence
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, UMS_OFS_MODEM_CONTROL, 32'h0);
      chk(rd[7:0], UMS_RST_MODEM_CONTROL);
      chk({6'h0, rts_n, dtr_n}, 8'h03);
      apb(1'b0, 8'h20, 32'h0);
      chk({7'h0, err}, 8'h01);
      chk(rd[7:0], 8'h00);
      for (int i = 0; i < 4; i++) begin
         pins_cmd <= pn_t[i];
         apb(1'b1, UMS_OFS_MODEM_CONTROL, {24'h0, mc_t[i]});
         apb(1'b0, UMS_OFS_MODEM_STATUS, 32'h0);
         chk({4'h0, rd[7:4]}, {4'h0, ex_t[i]});
         chk({6'h0, rts_n, dtr_n}, {6'h0, ~mc_t[i][1:0]});
      end
      apb(1'b1, UMS_OFS_MODEM_CONTROL, 32'h10);
      apb(1'b1, UMS_OFS_MODEM_CONTROL, 32'h00);
      // Immediate byte, then a buffered one
      apb(1'b1, UMS_OFS_MODEM_CONTROL, 32'h08);
      apb(1'b1, UMS_OFS_HOLDING, 32'hA5);
      apb(1'b1, UMS_OFS_HOLDING, 32'h3C);
      for (n = 0; ldq.size() < 2 && n < 100; n++) @(posedge pclk);
      guard();
      chk(ldq[0], 8'hA5);
      chk(ldq[1], 8'h3C);
      apb(1'b0, UMS_OFS_MODEM_CONTROL, 32'h0);
      chk({7'h0, rd[UMS_MC_SEND_IMM]}, 8'h00);
      // Armed, then another access cancels the request
      apb(1'b1, UMS_OFS_MODEM_CONTROL, 32'h08);
      apb(1'b0, UMS_OFS_LINE_STATUS, 32'h0);
      apb(1'b0, UMS_OFS_MODEM_CONTROL, 32'h0);
      chk(rd[7:0], 8'h00);
      // Receive errors and overrun at depth four
      apb(1'b1, UMS_OFS_FEATURE, 32'h1D);
      apb(1'b1, UMS_OFS_MODEM_CONTROL, 32'h20);
      rx(11'h1A1);
      chk(8'(xon_n), 8'h01);
      for (int i = 1; i < 5; i++) rx(11'(8'hA1 + 8'h11 * i));
      apb(1'b0, UMS_OFS_LINE_STATUS, 32'h0);
      chk(rd[7:0], 8'hE7);
      chk({7'h0, ls_irq}, 8'h01);
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, UMS_OFS_HOLDING, 32'h0);
         chk(rd[7:0], 8'(8'hA1 + 8'h11 * i));
      end
      apb(1'b0, UMS_OFS_LINE_STATUS, 32'h0);
      chk(rd[7:0], 8'h60);
      // Delta flags
      pins_cmd <= 4'hB;
      repeat (3) @(posedge pclk);
      apb(1'b0, UMS_OFS_MODEM_STATUS, 32'h0);
      pins_cmd <= 4'hE;
      repeat (3) @(posedge pclk);
      chk({7'h0, ms_irq}, 8'h01);
      apb(1'b0, UMS_OFS_MODEM_STATUS, 32'h0);
      chk(rd[7:0], 8'h15);
      apb(1'b0, UMS_OFS_MODEM_STATUS, 32'h0);
      chk(rd[7:0], 8'h10);
      pins_cmd <= 4'hA;
      repeat (3) @(posedge pclk);
      apb(1'b0, UMS_OFS_MODEM_STATUS, 32'h0);
      chk(rd[7:0], 8'h50);
      // Auto flow: DSR selected and high halts, CTS low resumes
      apb(1'b1, UMS_OFS_FEATURE, 32'h1F);
      apb(1'b1, UMS_OFS_MODEM_CONTROL, 32'h24);
      apb(1'b1, UMS_OFS_HOLDING, 32'h5A);
      repeat (8) @(posedge pclk);
      chk(8'(ldq.size()), 8'h02);
      apb(1'b1, UMS_OFS_MODEM_CONTROL, 32'h20);
      repeat (3) @(posedge pclk);
      chk(ldq[2], 8'h5A);
      // Break held while line low, then a framing error
      rxl <= 1'b0;
      rx(11'h400);
      rx(11'h400);
      apb(1'b0, UMS_OFS_HOLDING, 32'h0);
      chk(rd[7:0], 8'h00);
      apb(1'b0, UMS_OFS_LINE_STATUS, 32'h0);
      chk(rd[7:0], 8'h70);
      rxl <= 1'b1;
      rx(11'h2C3);
      apb(1'b0, UMS_OFS_LINE_STATUS, 32'h0);
      chk(rd[7:0], 8'hE9);
      results();
   end
endmodule : test_ums_modem_line_status

// File: verification/ums_modem_model.sv
//========
// Purpose: Far side: modem pins and transmit shifter
// Assumes: Pins follow pins_cmd one cycle late
// Notes:   Shifter stays busy four cycles per byte
//========
`timescale 1ns/100ps
module ums_modem_model (
   input  wire logic                        pclk,       // Clock
   input  wire logic                        presetn,    // Reset
   input  wire ums_pkg::ums_modem_pins_type pins_cmd,   // Wanted levels
   input  wire logic                        tsr_load,   // Load pulse
   output ums_pkg::ums_modem_pins_type      modem_pins, // Pin levels
   output logic                             tsr_idle    // Shifter free
);
   import ums_pkg::*;
   logic [2:0] busy_ff;
   // Pin levels and shifter occupancy
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         modem_pins <= '1;
         busy_ff <= 3'h0;
      end else begin
         modem_pins <= pins_cmd;
         if (tsr_load) busy_ff <= 3'h4;
         else if (busy_ff != 3'h0) busy_ff <= busy_ff - 3'h1;
      end
   end
   assign tsr_idle = (busy_ff == 3'h0);
endmodule : ums_modem_model
